/* File: tc16_pkg.sv */
// package for the 16-bit counter core: byte addresses, modes, reset values
// assumes an 8-bit cpu bus with one-cycle read and write strobes
package tc16_pkg;

    // ----------------------------------------
    // byte addresses of the 16-bit registers
    // ----------------------------------------
    localparam logic [3:0] ADDR_CNT_LO = 4'h0;
    localparam logic [3:0] ADDR_CNT_HI = 4'h1;
    localparam logic [3:0] ADDR_CMPA_LO = 4'h2;
    localparam logic [3:0] ADDR_CMPA_HI = 4'h3;
    localparam logic [3:0] ADDR_CMPB_LO = 4'h4;
    localparam logic [3:0] ADDR_CMPB_HI = 4'h5;
    localparam logic [3:0] ADDR_CMPC_LO = 4'h6;
    localparam logic [3:0] ADDR_CMPC_HI = 4'h7;
    localparam logic [3:0] ADDR_CAP_LO = 4'h8;
    localparam logic [3:0] ADDR_CAP_HI = 4'h9;

    // ----------------------------------------
    // counter values and reset values
    // ----------------------------------------
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic [2:0] CLK_SEL_STOP = 3'h0;

    // ----------------------------------------
    // mode field positions
    // ----------------------------------------
    localparam int WM_LO_A = 0;
    localparam int WM_B2 = 3;
    localparam int WM_B3 = 4;

    // ----------------------------------------
    // top source, derived from wave mode
    // ----------------------------------------
    typedef enum logic [2:0] {
        TOP_MAX = 3'b000,
        TOP_FIX8 = 3'b001,
        TOP_FIX9 = 3'b010,
        TOP_FIX10 = 3'b011,
        TOP_CMPA = 3'b100,
        TOP_CAP = 3'b101
    } top_src_e;

endpackage

/* File: tc16_seq.sv */
// counting sequence decoder: wave mode to top source and counting style
// assumes wave_mode is the full four-bit field from ctrl_a and ctrl_b
`timescale 1ns/1ps
module tc16_seq (
    input wire logic [3:0] wave_mode,
    output tc16_pkg::top_src_e top_src,
    output logic dual_slope,
    output logic clear_on_top
);
    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    always_comb
    begin
        top_src = tc16_pkg::TOP_MAX;
        dual_slope = 1'b0;
        clear_on_top = 1'b1;
        case (wave_mode)
            4'h0: top_src = tc16_pkg::TOP_MAX;
            4'h1:
            begin
                top_src = tc16_pkg::TOP_FIX8;
                dual_slope = 1'b1;
            end
            4'h2:
            begin
                top_src = tc16_pkg::TOP_FIX9;
                dual_slope = 1'b1;
            end
            4'h3:
            begin
                top_src = tc16_pkg::TOP_FIX10;
                dual_slope = 1'b1;
            end
            4'h4: top_src = tc16_pkg::TOP_CMPA;
            4'h5: top_src = tc16_pkg::TOP_FIX8;
            4'h6: top_src = tc16_pkg::TOP_FIX9;
            4'h7: top_src = tc16_pkg::TOP_FIX10;
            4'h8, 4'ha:
            begin
                top_src = tc16_pkg::TOP_CAP;
                dual_slope = 1'b1;
            end
            4'h9, 4'hb:
            begin
                top_src = tc16_pkg::TOP_CMPA;
                dual_slope = 1'b1;
            end
            4'hc: top_src = tc16_pkg::TOP_CAP;
            4'he: top_src = tc16_pkg::TOP_CAP;
            4'hf: top_src = tc16_pkg::TOP_CMPA;
            default: top_src = tc16_pkg::TOP_MAX;
        endcase
        if (wave_mode == 4'h0)
        begin
            clear_on_top = 1'b0;
        end
    end
endmodule

/* File: tc16_core.sv */
// 16-bit timer counter core with shared high-byte holding register
// assumes a cpu with one-cycle byte strobes and a one-cycle tick_clk qualifier
`timescale 1ns/1ps
module tc16_core (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic [3:0] CPU_ADDR,
    input wire logic [7:0] CPU_WDATA,
    input wire logic CPU_WR,
    input wire logic CPU_RD,
    output logic [7:0] CPU_RDATA,
    input wire logic [7:0] CTRL_A,
    input wire logic [7:0] CTRL_B,
    input wire logic [7:0] CTRL_C,
    input wire logic TICK_CLK,
    input wire logic OVF_CLEAR,
    input wire logic CMPC_FLAG_CLEAR,
    input wire logic CMPC_MASK,
    input wire logic OVF_MASK,
    output logic [15:0] COUNT_VALUE,
    output logic OVERFLOW_FLAG,
    output logic OVF_IRQ,
    output logic CMPC_FLAG,
    output logic CMPC_IRQ,
    output logic AT_BOTTOM,
    output logic AT_TOP,
    output logic [1:0] OUT_MODE_C,
    output logic FORCE_CMP_A,
    output logic FORCE_CMP_B,
    output logic FORCE_CMP_C
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] cmpa_q, cmpb_q, cmpc_q, cap_q;
    logic [7:0] hold_q, hold_d;
    logic [7:0] rdata_q, rdata_d;
    logic down_q, down_d;
    logic ovf_q, ovf_d, ovf_set;
    logic cfc_q, cfc_d;
    logic [2:0] clk_select;
    logic [3:0] wave_mode;
    tc16_pkg::top_src_e top_src;
    logic dual_slope, clear_on_top;
    logic [15:0] top_val;
    logic tick, at_top, at_bottom, at_max;
    logic wr_lo, rd_lo;
    logic [15:0] wr_word;

    // ----------------------------------------
    // control fields
    // ----------------------------------------
    assign clk_select = CTRL_B[2:0];
    assign wave_mode = {CTRL_B[tc16_pkg::WM_B3], CTRL_B[tc16_pkg::WM_B2],
        CTRL_A[tc16_pkg::WM_LO_A+1], CTRL_A[tc16_pkg::WM_LO_A]};
    assign OUT_MODE_C = CTRL_A[3:2];
    assign FORCE_CMP_A = CTRL_C[7];
    assign FORCE_CMP_B = CTRL_C[6];
    assign FORCE_CMP_C = CTRL_C[5];

    tc16_seq u_seq (
        .wave_mode(wave_mode),
        .top_src(top_src),
        .dual_slope(dual_slope),
        .clear_on_top(clear_on_top)
    );

    // ----------------------------------------
    // top and bottom
    // ----------------------------------------
    assign top_val = (top_src == tc16_pkg::TOP_FIX8) ? tc16_pkg::TOP_8BIT :
        (top_src == tc16_pkg::TOP_FIX9) ? tc16_pkg::TOP_9BIT :
        (top_src == tc16_pkg::TOP_FIX10) ? tc16_pkg::TOP_10BIT :
        (top_src == tc16_pkg::TOP_CMPA) ? cmpa_q :
        (top_src == tc16_pkg::TOP_CAP) ? cap_q : tc16_pkg::CNT_MAX;
    assign at_top = (cnt_q == top_val);
    assign at_bottom = (cnt_q == tc16_pkg::CNT_BOTTOM);
    assign at_max = (cnt_q == tc16_pkg::CNT_MAX);
    assign tick = TICK_CLK && (clk_select != tc16_pkg::CLK_SEL_STOP);

    // ----------------------------------------
    // cpu byte access
    // ----------------------------------------
    function automatic logic is_lo(input logic [3:0] a);
        is_lo = (a == tc16_pkg::ADDR_CNT_LO) || (a == tc16_pkg::ADDR_CMPA_LO) ||
            (a == tc16_pkg::ADDR_CMPB_LO) || (a == tc16_pkg::ADDR_CMPC_LO) ||
            (a == tc16_pkg::ADDR_CAP_LO);
    endfunction

    assign wr_lo = CPU_WR && is_lo(CPU_ADDR);
    assign rd_lo = CPU_RD && is_lo(CPU_ADDR);
    assign wr_word = {hold_q, CPU_WDATA};

    always_comb
    begin
        hold_d = hold_q;
        if (CPU_WR && !is_lo(CPU_ADDR) && CPU_ADDR <= tc16_pkg::ADDR_CAP_HI)
        begin
            hold_d = CPU_WDATA;
        end
        else if (CPU_RD)
        begin
            case (CPU_ADDR)
                tc16_pkg::ADDR_CNT_LO: hold_d = cnt_q[15:8];
                tc16_pkg::ADDR_CAP_LO: hold_d = cap_q[15:8];
                default: hold_d = hold_q;
            endcase
        end
    end

    always_comb
    begin
        rdata_d = rdata_q;
        if (CPU_RD)
        begin
            case (CPU_ADDR)
                tc16_pkg::ADDR_CNT_LO: rdata_d = cnt_q[7:0];
                tc16_pkg::ADDR_CNT_HI: rdata_d = hold_q;
                tc16_pkg::ADDR_CMPA_LO: rdata_d = cmpa_q[7:0];
                tc16_pkg::ADDR_CMPA_HI: rdata_d = cmpa_q[15:8];
                tc16_pkg::ADDR_CMPB_LO: rdata_d = cmpb_q[7:0];
                tc16_pkg::ADDR_CMPB_HI: rdata_d = cmpb_q[15:8];
                tc16_pkg::ADDR_CMPC_LO: rdata_d = cmpc_q[7:0];
                tc16_pkg::ADDR_CMPC_HI: rdata_d = cmpc_q[15:8];
                tc16_pkg::ADDR_CAP_LO: rdata_d = cap_q[7:0];
                tc16_pkg::ADDR_CAP_HI: rdata_d = hold_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // counter unit
    // ----------------------------------------
    always_comb
    begin
        cnt_d = cnt_q;
        down_d = down_q;
        ovf_set = 1'b0;
        if (tick)
        begin
            if (dual_slope)
            begin
                down_d = (down_q && !at_bottom) || (!down_q && at_top);
                ovf_set = down_q && at_bottom;
                cnt_d = down_d ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
            end
            else if (clear_on_top && at_top)
            begin
                cnt_d = tc16_pkg::CNT_BOTTOM;
                ovf_set = (top_src != tc16_pkg::TOP_CMPA) || (wave_mode == 4'hf);
            end
            else
            begin
                cnt_d = cnt_q + 16'h0001;
                ovf_set = at_max;
            end
        end
        ovf_d = ovf_set || (ovf_q && !OVF_CLEAR);
        if (wr_lo && CPU_ADDR == tc16_pkg::ADDR_CNT_LO)
        begin
            cnt_d = wr_word;
        end
    end

    assign cfc_d = (tick && cnt_q == cmpc_q) ? 1'b1 : (CMPC_FLAG_CLEAR ? 1'b0 : cfc_q);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            cnt_q <= tc16_pkg::CNT_RESET;
            hold_q <= tc16_pkg::HOLD_RESET;
            rdata_q <= 8'h00;
            down_q <= 1'b0;
            ovf_q <= 1'b0;
            cfc_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            rdata_q <= rdata_d;
            down_q <= down_d;
            ovf_q <= ovf_d;
            cfc_q <= cfc_d;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            cmpa_q <= 16'h0000;
            cmpb_q <= 16'h0000;
            cmpc_q <= 16'h0000;
            cap_q <= 16'h0000;
        end
        else if (wr_lo)
        begin
            if (CPU_ADDR == tc16_pkg::ADDR_CMPA_LO) cmpa_q <= wr_word;
            if (CPU_ADDR == tc16_pkg::ADDR_CMPB_LO) cmpb_q <= wr_word;
            if (CPU_ADDR == tc16_pkg::ADDR_CMPC_LO) cmpc_q <= wr_word;
            if (CPU_ADDR == tc16_pkg::ADDR_CAP_LO) cap_q <= wr_word;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign CPU_RDATA = rdata_q;
    assign COUNT_VALUE = cnt_q;
    assign OVERFLOW_FLAG = ovf_q;
    assign OVF_IRQ = ovf_q && OVF_MASK;
    assign CMPC_FLAG = cfc_q;
    assign CMPC_IRQ = cfc_q && CMPC_MASK;
    assign AT_BOTTOM = at_bottom;
    assign AT_TOP = at_top;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_wr_lo_cnt;
        @(posedge REF_CLK) disable iff (RESET)
        (CPU_WR && CPU_ADDR == tc16_pkg::ADDR_CNT_LO) |=>
            cnt_q == {$past(hold_q), $past(CPU_WDATA)};
    endproperty
    a_wr_lo_cnt: assert property (p_wr_lo_cnt) else $error("low write did not load count");

    property p_rd_lo_hold;
        @(posedge REF_CLK) disable iff (RESET)
        (CPU_RD && !CPU_WR && CPU_ADDR == tc16_pkg::ADDR_CNT_LO) |=> hold_q == $past(cnt_q[15:8]);
    endproperty
    a_rd_lo_hold: assert property (p_rd_lo_hold) else $error("hold missed low read");

    property p_hi_wr_hold;
        @(posedge REF_CLK) disable iff (RESET)
        (CPU_WR && CPU_ADDR == tc16_pkg::ADDR_CNT_HI) |=> hold_q == $past(CPU_WDATA) &&
            ($stable(cnt_q[15:8]) || $past(tick));
    endproperty
    a_hi_wr_hold: assert property (p_hi_wr_hold) else $error("high write missed holding");

    property p_cmp_rd;
        @(posedge REF_CLK) disable iff (RESET)
        (CPU_RD && !CPU_WR && CPU_ADDR == tc16_pkg::ADDR_CMPA_HI) |=>
            CPU_RDATA == $past(cmpa_q[15:8]) && $stable(hold_q);
    endproperty
    a_cmp_rd: assert property (p_cmp_rd) else $error("compare read used holding");

    property p_stop;
        @(posedge REF_CLK) disable iff (RESET)
        (clk_select == tc16_pkg::CLK_SEL_STOP && !CPU_WR) |=> $stable(cnt_q);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_wr_prio;
        @(posedge REF_CLK) disable iff (RESET)
        (tick && CPU_WR && CPU_ADDR == tc16_pkg::ADDR_CNT_LO) |=> cnt_q[7:0] == $past(CPU_WDATA);
    endproperty
    a_wr_prio: assert property (p_wr_prio) else $error("count beat cpu write");

    property p_normal_inc;
        @(posedge REF_CLK) disable iff (RESET)
        (tick && wave_mode == 4'h0 && !CPU_WR) |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_normal_inc: assert property (p_normal_inc) else $error("count did not increment");

    property p_wrap_ovf;
        @(posedge REF_CLK) disable iff (RESET)
        (tick && wave_mode == 4'h0 && at_max && !CPU_WR) |=> cnt_q == 16'h0000 && ovf_q;
    endproperty
    a_wrap_ovf: assert property (p_wrap_ovf) else $error("no wrap with overflow");
endmodule

/* File: tc16_host.sv */
// host cpu model: byte reads and writes on the timer bus
// assumes one-cycle strobes and read data valid one cycle after the strobe
`timescale 1ns/1ps
module tc16_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    // ----------------
    // bus access tasks
    // ----------------
    initial
    begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // one byte access, strobe held for exactly one edge; calls never overlap
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(posedge clk);
        #1;
        wr = 1'b0;
        rd = 1'b0;
        addr = ~a;
        wdata = ~d;
        q = rdata;
    endtask

    // high byte first, then low byte
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        logic [7:0] q;
        acc(1'b1, lo + 4'h1, v[15:8], q);
        acc(1'b1, lo, v[7:0], q);
    endtask

    // low byte first, then high byte
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        acc(1'b0, lo, 8'h00, v[7:0]);
        acc(1'b0, lo + 4'h1, 8'h00, v[15:8]);
    endtask
endmodule

/* File: sixteen_bit_counter_core_bench.sv */
// testbench for the 16-bit counter core with a host cpu model
// assumes tc16_pkg, tc16_core and tc16_host are compiled first
`timescale 1ns/1ps
module sixteen_bit_counter_core_bench;
    // ----------------
    // signals and instances
    // ----------------
    logic clk, reset, wr, rd, tick, ovf_clr, cmpc_clr, cmpc_mask, ovf_mask;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, ctrl_a, ctrl_b, ctrl_c, q;
    logic [15:0] count, v;
    logic ovf_flag, ovf_irq, cmpc_flag, cmpc_irq, at_bot, at_top, fa, fb, fc;
    logic [1:0] out_mode_c;
    int errors = 0;
    int n_tests = 0;

    tc16_core i_dut (.REF_CLK(clk), .RESET(reset), .CPU_ADDR(addr), .CPU_WDATA(wdata),
        .CPU_WR(wr), .CPU_RD(rd), .CPU_RDATA(rdata), .CTRL_A(ctrl_a), .CTRL_B(ctrl_b),
        .CTRL_C(ctrl_c), .TICK_CLK(tick), .OVF_CLEAR(ovf_clr),
        .CMPC_FLAG_CLEAR(cmpc_clr), .CMPC_MASK(cmpc_mask), .OVF_MASK(ovf_mask),
        .COUNT_VALUE(count), .OVERFLOW_FLAG(ovf_flag), .OVF_IRQ(ovf_irq),
        .CMPC_FLAG(cmpc_flag), .CMPC_IRQ(cmpc_irq), .AT_BOTTOM(at_bot), .AT_TOP(at_top),
        .OUT_MODE_C(out_mode_c), .FORCE_CMP_A(fa), .FORCE_CMP_B(fb), .FORCE_CMP_C(fc));
    tc16_host i_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd));

    // ----------------
    // helpers
    // ----------------
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
            errors++;
        end
    endtask

    task automatic tick_n(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            tick = 1'b1;
            @(posedge clk);
            #1;
            tick = 1'b0;
        end
    endtask

    task automatic clr_flags();
        @(posedge clk);
        #1;
        ovf_clr = 1'b1;
        cmpc_clr = 1'b1;
        @(posedge clk);
        #1;
        ovf_clr = 1'b0;
        cmpc_clr = 1'b0;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------
    // scenarios
    // ----------------
    task automatic t_access();
        ctrl_b = 8'h00;
        chk_word("reset count", 16'h0000, count);
        chk_bit("reset bottom", 1'b1, at_bot);
        i_host.acc(1'b1, tc16_pkg::ADDR_CNT_HI, 8'h01, q);
        chk_word("count after hi", 16'h0000, count);
        i_host.acc(1'b1, 4'hb, 8'h77, q);
        i_host.acc(1'b1, tc16_pkg::ADDR_CNT_LO, 8'hff, q);
        chk_word("count after lo", 16'h01ff, count);
        tick_n(3);
        chk_word("stopped count", 16'h01ff, count);
        i_host.rd16(tc16_pkg::ADDR_CNT_LO, v);
        chk_word("count read", 16'h01ff, v);
        i_host.acc(1'b1, tc16_pkg::ADDR_CMPB_LO, 8'h33, q);
        i_host.rd16(tc16_pkg::ADDR_CMPB_LO, v);
        chk_word("cmpb from hold", 16'h0133, v);
        i_host.acc(1'b0, 4'ha, 8'h00, q);
        chk_word("unmapped read", 16'h0000, {8'h00, q});
        $display("test access done");
    endtask

    task automatic t_shared();
        i_host.acc(1'b1, tc16_pkg::ADDR_CMPA_HI, 8'hab, q);
        i_host.acc(1'b1, tc16_pkg::ADDR_CMPA_LO, 8'h12, q);
        i_host.acc(1'b1, tc16_pkg::ADDR_CMPC_LO, 8'h34, q);
        i_host.rd16(tc16_pkg::ADDR_CMPC_LO, v);
        chk_word("cmpc shared hi", 16'hab34, v);
        i_host.acc(1'b0, tc16_pkg::ADDR_CNT_LO, 8'h00, q);
        i_host.acc(1'b0, tc16_pkg::ADDR_CMPA_HI, 8'h00, q);
        chk_word("cmpa hi direct", 16'h00ab, {8'h00, q});
        $display("test shared done");
    endtask

    task automatic t_count();
        ctrl_b = 8'h01;
        i_host.wr16(tc16_pkg::ADDR_CNT_LO, 16'hfffe);
        tick_n(1);
        chk_word("count up", 16'hffff, count);
        chk_bit("top at max", 1'b1, at_top);
        tick_n(1);
        chk_word("count wrap", 16'h0000, count);
        chk_bit("bottom", 1'b1, at_bot);
        chk_bit("ovf flag", 1'b1, ovf_flag);
        ovf_mask = 1'b1;
        #1;
        chk_bit("ovf irq", 1'b1, ovf_irq);
        clr_flags();
        chk_bit("ovf cleared", 1'b0, ovf_flag);
        tick = 1'b1;
        i_host.wr16(tc16_pkg::ADDR_CNT_LO, 16'h1234);
        chk_word("write beats tick", 16'h1234, count);
        tick = 1'b0;
        $display("test count done");
    endtask

    task automatic t_modes();
        logic [3:0] m[7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf};
        logic [15:0] t[7] = '{16'h0010, 16'h00ff, 16'h01ff, 16'h03ff, 16'h0020, 16'h0020,
            16'h0010};
        i_host.wr16(tc16_pkg::ADDR_CMPA_LO, 16'h0010);
        i_host.wr16(tc16_pkg::ADDR_CAP_LO, 16'h0020);
        for (int i = 0; i < 7; i++)
        begin
            ctrl_a = {6'h00, m[i][1:0]};
            ctrl_b = {3'h0, m[i][3], m[i][2], 3'h1};
            i_host.wr16(tc16_pkg::ADDR_CNT_LO, t[i] - 16'h0001);
            clr_flags();
            tick_n(1);
            chk_bit("at top", 1'b1, at_top);
            tick_n(1);
            chk_word("cleared at top", 16'h0000, count);
            chk_bit("ovf at top", m[i] != 4'h4, ovf_flag);
        end
        ctrl_a = 8'h01;
        ctrl_b = 8'h01;
        i_host.wr16(tc16_pkg::ADDR_CNT_LO, 16'h00fe);
        tick_n(2);
        chk_word("dual slope down", 16'h00fe, count);
        i_host.wr16(tc16_pkg::ADDR_CNT_LO, 16'h0001);
        clr_flags();
        tick_n(2);
        chk_word("dual slope up", 16'h0001, count);
        chk_bit("ovf at bottom", 1'b1, ovf_flag);
        $display("test modes done");
    endtask

    task automatic t_cmpc();
        ctrl_a = 8'h08;
        ctrl_b = 8'h01;
        ctrl_c = 8'ha0;
        #1;
        chk_word("force and out mode", 16'h0016, {11'h000, fa, fb, fc, out_mode_c});
        i_host.wr16(tc16_pkg::ADDR_CMPC_LO, 16'h0005);
        i_host.wr16(tc16_pkg::ADDR_CNT_LO, 16'h0005);
        clr_flags();
        tick_n(1);
        chk_bit("cmpc flag", 1'b1, cmpc_flag);
        chk_bit("cmpc irq masked", 1'b0, cmpc_irq);
        cmpc_mask = 1'b1;
        #1;
        chk_bit("cmpc irq", 1'b1, cmpc_irq);
        clr_flags();
        chk_bit("cmpc cleared", 1'b0, cmpc_flag);
        $display("test cmpc done");
    endtask

    // ----------------
    // clock, reset, sequence
    // ----------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #200000;
        errors++;
        end_sim();
    end

    initial
    begin
        reset = 1'b1;
        tick = 1'b0;
        ovf_clr = 1'b0;
        cmpc_clr = 1'b0;
        cmpc_mask = 1'b0;
        ovf_mask = 1'b0;
        ctrl_a = 8'h00;
        ctrl_b = 8'h00;
        ctrl_c = 8'h00;
        repeat (16) @(posedge clk);
        #1;
        reset = 1'b0;
        t_access();
        t_shared();
        t_count();
        t_modes();
        t_cmpc();
        end_sim();
    end
endmodule
